//--- src/bil_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "bil_defines.svh"
module bil_loader import bil_pkg::*; #(
    parameter logic [23:0] DELAY_CYC = 24'(`BIL_DELAY_CYC),
    parameter logic [23:0] TMO_CYC   = 24'(`BIL_TMO_CYC)
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         cmd_valid,
    input  wire logic         cmd_fast,
    input  wire logic         cmd_dest_valid,
    input  wire logic         cmd_dest_flash,
    input  wire logic         line_done,
    input  wire logic         rx_valid,
    input  wire logic [7:0]   rx_data,
    input  wire logic         tx_ready,
    input  wire logic         tx_empty,
    input  wire logic         mem_busy,
    output logic              tx_valid,
    output logic      [7:0]   tx_data,
    output logic      [1:0]   rate_sel,
    output logic              binary_mode,
    output logic              sts_lower,
    output logic              sts_upper,
    output logic              ready_prompt,
    output logic              mem_wr,
    output logic              mem_sel_flash,
    output logic      [31:0]  mem_addr,
    output logic      [26:0]  mem_rec,
    output logic      [255:0] mem_data
);
    bil_regs_t  r;
    bil_regs_t  next_r;
    logic [7:0] sum;
    logic       sum_add;
    logic       sum_clr;

    // ****************************************
    // Packet sum
    // ****************************************
    // The SOH restarts the sum, so stray bytes before it never count.
    assign sum_clr = (r.st == BIL_HUNT);
    assign sum_add = rx_valid && ((r.st == BIL_COLL) ||
                     (r.st == BIL_HUNT && rx_data == `BIL_SOH));

    bil_sum u_sum (
        .core_clk (core_clk),
        .nrst     (nrst),
        .clr      (sum_clr),
        .add      (sum_add),
        .data     (rx_data),
        .sum      (sum)
    );

    // ****************************************
    // Loader sequence
    // ****************************************
    // One pass per cycle; pulses default low and are raised for a single cycle.
    always_comb begin
        next_r           = r;
        next_r.sts_lower = 1'b0;
        next_r.sts_upper = 1'b0;
        next_r.prompt    = 1'b0;
        next_r.mem_wr    = 1'b0;
        if (r.timer != 24'h0) begin
            next_r.timer = r.timer - 24'h1;
        end
        unique case (r.st)
            BIL_IDLE: begin
                if (cmd_valid && cmd_dest_valid) begin
                    next_r.dest_flash = cmd_dest_flash;
                    next_r.binary     = 1'b1;
                    next_r.sts_lower  = 1'b1;
                    next_r.st         = BIL_STS;
                end else if (cmd_valid) begin
                    next_r.rate = cmd_fast ? `BIL_RATE_HIGH : `BIL_RATE_MED;
                end
            end
            BIL_STS: begin
                // The status line leaves at the old rate before the switch.
                if (line_done) begin
                    next_r.rate  = cmd_fast_q(r.rate, cmd_fast);
                    next_r.timer = DELAY_CYC;
                    next_r.st    = BIL_DLY1;
                end
            end
            BIL_DLY1: begin
                if (r.timer == 24'h0) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data  = `BIL_ACK;
                    next_r.st       = BIL_REPLY;
                end
            end
            BIL_HUNT: begin
                if (rx_valid && rx_data == `BIL_SOH) begin
                    next_r.cnt = 6'h01;
                    next_r.st  = BIL_COLL;
                end
            end
            BIL_COLL: begin
                if (rx_valid) begin
                    if (r.cnt == `BIL_IDX_LEN) begin
                        next_r.len = rx_data;
                    end
                    if (r.cnt >= `BIL_IDX_ADDR0 && r.cnt <= `BIL_IDX_ADDR3) begin
                        next_r.addr = {r.addr[23:0], rx_data};
                    end
                    if (r.cnt >= `BIL_IDX_DATA0 && r.cnt <= `BIL_IDX_DATA31) begin
                        next_r.payload = {r.payload[247:0], rx_data};
                    end
                    next_r.cnt = r.cnt + 6'h01;
                    if (r.cnt == `BIL_PKT_BYTES - 6'h01) begin
                        next_r.st = BIL_CHECK;
                    end
                end
            end
            BIL_CHECK: begin
                next_r.ending = 1'b0;
                if (sum != 8'h00 ||
                    (r.len != 8'h00 && r.len != `BIL_LEN_DATA)) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data  = `BIL_NAK;
                    next_r.st       = BIL_REPLY;
                end else if (r.len == 8'h00) begin
                    next_r.ending = 1'b1;
                    if (!r.dest_flash) begin
                        // End marker lands right after the last record written.
                        next_r.addr    = r.next_free;
                        next_r.payload = '0;
                        next_r.st      = BIL_WRITE;
                    end else begin
                        next_r.tx_valid = 1'b1;
                        next_r.tx_data  = `BIL_ACK;
                        next_r.st       = BIL_REPLY;
                    end
                end else begin
                    next_r.st = BIL_WRITE;
                end
            end
            BIL_WRITE: begin
                next_r.mem_wr    = 1'b1;
                next_r.mem_addr  = r.addr;
                next_r.mem_rec   = r.addr[31:`BIL_REC_SHIFT];
                next_r.next_free = r.addr + 32'(`BIL_LEN_DATA);
                next_r.timer     = TMO_CYC;
                next_r.st        = BIL_POLL;
            end
            BIL_POLL: begin
                // The first cycle is skipped so busy has time to rise.
                if (r.timer != TMO_CYC && !mem_busy) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data  = `BIL_ACK;
                    next_r.st       = BIL_REPLY;
                end else if (r.timer == 24'h0) begin
                    next_r.tx_valid = 1'b1;
                    next_r.tx_data  = `BIL_NAK;
                    next_r.ending   = 1'b0;
                    next_r.st       = BIL_REPLY;
                end
            end
            BIL_REPLY: begin
                if (tx_ready) begin
                    next_r.tx_valid = 1'b0;
                    next_r.st = (r.ending && r.tx_data == `BIL_ACK) ? BIL_DRAIN : BIL_HUNT;
                end
            end
            BIL_DRAIN: begin
                if (tx_empty) begin
                    next_r.rate  = `BIL_RATE_BASE;
                    next_r.timer = DELAY_CYC;
                    next_r.st    = BIL_DLY2;
                end
            end
            BIL_DLY2: begin
                if (r.timer == 24'h0) begin
                    next_r.sts_upper = 1'b1;
                    next_r.st        = BIL_FIN;
                end
            end
            BIL_FIN: begin
                if (line_done) begin
                    next_r.prompt = 1'b1;
                    next_r.binary = 1'b0;
                    next_r.ending = 1'b0;
                    next_r.st     = BIL_IDLE;
                end
            end
            default: begin
                next_r.st = BIL_IDLE;
            end
        endcase
    end

    // Rate selected by the command that opened the load.
    function automatic logic [1:0] cmd_fast_q(input logic [1:0] cur, input logic fast);
        cmd_fast_q = fast ? `BIL_RATE_HIGH : `BIL_RATE_MED;
        if (cur == 2'h3) begin
            cmd_fast_q = `BIL_RATE_BASE;
        end
    endfunction : cmd_fast_q

    // State register; a reset also recovers a stuck load.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tx_valid      = r.tx_valid;
    assign tx_data       = r.tx_data;
    assign rate_sel      = r.rate;
    assign binary_mode   = r.binary;
    assign sts_lower     = r.sts_lower;
    assign sts_upper     = r.sts_upper;
    assign ready_prompt  = r.prompt;
    assign mem_wr        = r.mem_wr;
    assign mem_sel_flash = r.dest_flash;
    assign mem_addr      = r.mem_addr;
    assign mem_rec       = r.mem_rec;
    assign mem_data      = r.payload;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_bad_pkt;
        r.st == BIL_CHECK && sum != 8'h00;
    endsequence
    sequence s_nak_out;
        tx_valid && tx_data == `BIL_NAK;
    endsequence

    property p_entry;
        r.st == BIL_IDLE && cmd_valid && cmd_dest_valid |=> sts_lower && binary_mode;
    endproperty
    a_entry: assert property (p_entry) else $error("Entry lacks status line.");
    property p_nomod;
        r.st == BIL_IDLE && cmd_valid && !cmd_dest_valid
            |=> !binary_mode && rate_sel != `BIL_RATE_BASE;
    endproperty
    a_nomod: assert property (p_nomod) else $error("Rate-only command misbehaved.");
    property p_bad;
        s_bad_pkt |=> s_nak_out ##0 !mem_wr ##1 !mem_wr;
    endproperty
    a_bad: assert property (p_bad) else $error("Bad sum not refused.");
    property p_ack_done;
        r.st == BIL_POLL && r.timer != TMO_CYC && !mem_busy
            |=> tx_valid && tx_data == `BIL_ACK;
    endproperty
    a_ack_done: assert property (p_ack_done) else $error("No ACK after program.");
    property p_tmo;
        r.st == BIL_POLL && r.timer == 24'h0 && mem_busy |=> s_nak_out;
    endproperty
    a_tmo: assert property (p_tmo) else $error("Timeout did not NAK.");
    property p_hold;
        mem_wr |-> ##1 (!(tx_valid && tx_data == `BIL_ACK)) [*2];
    endproperty
    a_hold: assert property (p_hold) else $error("ACK before programming.");
    property p_drain;
        $changed(rate_sel) && rate_sel == `BIL_RATE_BASE && binary_mode
            |-> $past(tx_empty) && !tx_valid;
    endproperty
    a_drain: assert property (p_drain) else $error("Rate dropped early.");
    property p_marker;
        r.st == BIL_CHECK && sum == 8'h00 && r.len == 8'h00 && !r.dest_flash
            |=> ##1 mem_wr && mem_data == '0 && mem_addr == $past(r.next_free, 2);
    endproperty
    a_marker: assert property (p_marker) else $error("Missing end marker.");
    property p_rec;
        mem_wr |-> mem_rec == mem_addr[31:`BIL_REC_SHIFT];
    endproperty
    a_rec: assert property (p_rec) else $error("Record number wrong.");
    property p_fin;
        sts_upper |-> (binary_mode && rate_sel == `BIL_RATE_BASE) ##1 rate_sel == `BIL_RATE_BASE;
    endproperty
    a_fin: assert property (p_fin) else $error("Finish out of order.");
endmodule : bil_loader
`default_nettype wire

//--- src/bil_defines.svh
`ifndef BIL_DEFINES_SVH
`define BIL_DEFINES_SVH
// ****************************************
// Framing characters and packet layout
// ****************************************
`define BIL_SOH       8'h01
`define BIL_EOT       8'h04
`define BIL_ACK       8'h06
`define BIL_NAK       8'h15
`define BIL_PKT_BYTES 6'h2A
`define BIL_LEN_DATA  8'h20
`define BIL_IDX_LEN   6'h01
`define BIL_IDX_ADDR0 6'h02
`define BIL_IDX_ADDR3 6'h05
`define BIL_IDX_DATA0 6'h08
`define BIL_IDX_DATA31 6'h27
`define BIL_REC_SHIFT 5
// ****************************************
// Bit rate codes
// ****************************************
`define BIL_RATE_BASE 2'h0
`define BIL_RATE_MED  2'h1
`define BIL_RATE_HIGH 2'h2
// ****************************************
// Timing
// ****************************************
`define BIL_CLK_KHZ     100000
`define BIL_DELAY_MS    100
`define BIL_DELAY_CYC   (`BIL_DELAY_MS * `BIL_CLK_KHZ)
`define BIL_TMO_US      10000
`define BIL_TMO_CYC     (`BIL_TMO_US * (`BIL_CLK_KHZ / 1000))
`endif

//--- src/bil_pkg.sv
package bil_pkg;
    typedef enum logic [3:0] {
        BIL_IDLE  = 4'h0,
        BIL_STS   = 4'h1,
        BIL_DLY1  = 4'h2,
        BIL_HUNT  = 4'h3,
        BIL_COLL  = 4'h4,
        BIL_CHECK = 4'h5,
        BIL_WRITE = 4'h6,
        BIL_POLL  = 4'h7,
        BIL_REPLY = 4'h8,
        BIL_DRAIN = 4'h9,
        BIL_DLY2  = 4'hA,
        BIL_FIN   = 4'hB
    } bil_state_t;

    typedef struct packed {
        bil_state_t   st;
        logic [5:0]   cnt;
        logic [7:0]   len;
        logic [31:0]  addr;
        logic [255:0] payload;
        logic [23:0]  timer;
        logic         ending;
        logic         dest_flash;
        logic [1:0]   rate;
        logic         binary;
        logic         tx_valid;
        logic [7:0]   tx_data;
        logic         sts_lower;
        logic         sts_upper;
        logic         prompt;
        logic         mem_wr;
        logic [31:0]  mem_addr;
        logic [26:0]  mem_rec;
        logic [31:0]  next_free;
    } bil_regs_t;
endpackage : bil_pkg

//--- src/bil_sum.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Running modulo-256 packet sum
// ****************************************
module bil_sum (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       clr,
    input  wire logic       add,
    input  wire logic [7:0] data,
    output logic      [7:0] sum
);
    typedef struct packed {
        logic [7:0] acc;
    } bil_sum_t;
    bil_sum_t r;
    bil_sum_t next_r;

    // Carries out of bit 7 fall off; a clear with add restarts on this byte.
    always_comb begin
        next_r = r;
        if (add) begin
            next_r.acc = (clr ? 8'h00 : r.acc) + data;
        end
    end

    // State register.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sum = r.acc;
endmodule : bil_sum
`default_nettype wire

//--- tb/bil_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// External memory programming model
// ****************************************
module bil_mem_model (
    input  wire logic       core_clk,
    input  wire logic       nrst,
    input  wire logic       mem_wr,
    input  wire logic [7:0] busy_len,
    output logic            mem_busy
);
    logic [7:0] left;

    // Busy shows the cycle after a write; a long setting outlasts the poll window.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            left <= 8'h00;
        end else if (mem_wr) begin
            left <= busy_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end

    // Status register reads busy until the count runs out.
    assign mem_busy = (left != 8'h00);
endmodule : bil_mem_model
`default_nettype wire

//--- tb/tb_binary_image_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "bil_defines.svh"
`define CHK(g, e) check_val(256'(g), 256'(e))
module tb_binary_image_loader;
    import bil_pkg::*;
    localparam int DLY = 20;
    localparam int TMO = 10;
    logic core_clk = 1'h0, nrst = 1'h0, cmd_valid = 1'h0, cmd_fast = 1'h0;
    logic cmd_dest_valid = 1'h0, cmd_dest_flash = 1'h0, line_done = 1'h0;
    logic rx_valid = 1'h0, tx_ready = 1'h0, tx_empty = 1'h1;
    logic [7:0] rx_data = 8'h00, busy_len = 8'h05, tx_hold = 8'h00, seed = 8'h5B, eb;
    logic [1:0] rate_sel, cyc = 2'h0;
    logic tx_valid, binary_mode, sts_lower, sts_upper, ready_prompt;
    logic mem_wr, mem_sel_flash, mem_busy, exp_fl = 1'h0;
    logic [7:0] tx_data;
    logic [31:0] mem_addr, ea;
    logic [26:0] mem_rec;
    logic [255:0] mem_data, ed;
    logic [7:0] exp_tx[$];
    logic [31:0] exp_wa[$];
    logic [255:0] exp_wd[$];
    int fails = 0, checks_done = 0;

    bil_loader #(.DELAY_CYC(24'(DLY)), .TMO_CYC(24'(TMO))) dut_u (
        .core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_fast(cmd_fast),
        .cmd_dest_valid(cmd_dest_valid), .cmd_dest_flash(cmd_dest_flash),
        .line_done(line_done), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_ready(tx_ready), .tx_empty(tx_empty), .mem_busy(mem_busy),
        .tx_valid(tx_valid), .tx_data(tx_data), .rate_sel(rate_sel),
        .binary_mode(binary_mode), .sts_lower(sts_lower), .sts_upper(sts_upper),
        .ready_prompt(ready_prompt), .mem_wr(mem_wr), .mem_sel_flash(mem_sel_flash),
        .mem_addr(mem_addr), .mem_rec(mem_rec), .mem_data(mem_data));
    bil_mem_model mem_u (.core_clk(core_clk), .nrst(nrst), .mem_wr(mem_wr),
        .busy_len(busy_len), .mem_busy(mem_busy));

    // ****************************************
    // Clock, helpers and verdict
    // ****************************************
    always #5 core_clk = ~core_clk;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next

    task automatic check_val(input logic [255:0] got, input logic [255:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic close_out;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask : tick

    // Waits for the monitor to consume every expected reply, with a bound.
    task automatic wait_tx;
        for (int n = 0; n < 300 && exp_tx.size() != 0; n++) tick;
        `CHK(exp_tx.size(), 0);
    endtask : wait_tx

    task automatic rx_byte(input logic [7:0] v);
        rx_valid = 1'h1;
        rx_data = v;
        tick;
        rx_valid = 1'h0;
        tick;
    endtask : rx_byte

    // Enters loading; cmd_fast stays put until line_done, as the interpreter holds it.
    task automatic enter(input logic fast, input logic flash);
        logic seen;
        exp_fl = flash;
        cmd_valid = 1'h1;
        cmd_fast = fast;
        cmd_dest_valid = 1'h1;
        cmd_dest_flash = flash;
        tick;
        cmd_valid = 1'h0;
        cmd_dest_valid = 1'h0;
        `CHK(sts_lower, 1'h1);
        `CHK(binary_mode, 1'h1);
        exp_tx.push_back(`BIL_ACK);
        repeat (3) tick;
        line_done = 1'h1;
        tick;
        line_done = 1'h0;
        seen = 1'h0;
        for (int n = 0; n < DLY - 3; n++) begin
            tick;
            seen = seen | tx_valid;
        end
        `CHK(rate_sel, fast ? `BIL_RATE_HIGH : `BIL_RATE_MED);
        `CHK(seen, 1'h0);
        wait_tx;
    endtask : enter

    // Builds one 42-byte packet, notes the expected write and reply, sends it.
    task automatic pkt(input logic [7:0] len, input logic [31:0] addr, input logic bad,
                       input logic [7:0] busy, input logic wr, input logic [31:0] wa,
                       input logic [7:0] reply);
        logic [7:0] b [42];
        logic [7:0] s;
        logic [255:0] pl;
        b = '{default: 8'h00};
        s = 8'h00;
        pl = '0;
        busy_len = busy;
        b[0] = `BIL_SOH;
        b[1] = len;
        {b[2], b[3], b[4], b[5]} = addr;
        b[41] = `BIL_EOT;
        for (int i = 8; i < 40; i++) begin
            if (len == `BIL_LEN_DATA) begin
                seed = lfsr_next(seed);
                b[i] = seed;
            end
            pl = {pl[247:0], b[i]};
        end
        for (int i = 0; i < 42; i++) s = s + b[i];
        b[40] = 8'h00 - s + {7'h00, bad};
        if (wr) begin
            exp_wa.push_back(wa);
            exp_wd.push_back(pl);
        end
        exp_tx.push_back(reply);
        rx_byte(8'h55);
        for (int i = 0; i < 42; i++) rx_byte(b[i]);
        wait_tx;
    endtask : pkt

    task automatic finish_load(input logic [1:0] old);
        int n;
        repeat (4) tick;
        `CHK(rate_sel, old);
        for (n = 0; n < 40 && rate_sel != `BIL_RATE_BASE; n++) tick;
        `CHK(rate_sel, `BIL_RATE_BASE);
        for (n = 0; n < DLY + 20 && !sts_upper; n++) tick;
        `CHK(n >= DLY - 2, 1'h1);
        `CHK(sts_upper, 1'h1);
        line_done = 1'h1;
        tick;
        line_done = 1'h0;
        `CHK(ready_prompt, 1'h1);
        `CHK(binary_mode, 1'h0);
    endtask : finish_load

    // ****************************************
    // Serial sink: stalls one cycle in four, shifter busy 12 cycles per byte
    // ****************************************
    always @(posedge core_clk) begin
        #1;
        cyc = cyc + 2'h1;
        tx_ready = (cyc != 2'h0);
        tx_empty = (tx_hold == 8'h00);
    end

    // Monitor takes the oldest note whenever a reply or a write appears.
    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) begin
            `CHK(exp_tx.size() != 0, 1'h1);
            if (exp_tx.size() != 0) begin
                eb = exp_tx.pop_front();
                `CHK(tx_data, eb);
                if (eb == `BIL_ACK) `CHK(mem_busy, 1'h0);
            end
            tx_hold <= 8'h0C;
        end else if (tx_hold != 8'h00) begin
            tx_hold <= tx_hold - 8'h01;
        end
        if (mem_wr) begin
            `CHK(exp_wa.size() != 0, 1'h1);
            if (exp_wa.size() != 0) begin
                ea = exp_wa.pop_front();
                ed = exp_wd.pop_front();
                `CHK(mem_sel_flash, exp_fl);
                `CHK(mem_addr, ea);
                `CHK(mem_rec, ea >> 5);
                `CHK(mem_data, ed);
            end
        end
    end

    // Watchdog: the whole sequence needs well under 10,000 cycles.
    initial begin
        #200000;
        fails++;
        close_out;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge core_clk);
        #1;
        nrst = 1'h1;
        `CHK(binary_mode, 1'h0);
        tick;
        for (int f = 0; f < 2; f++) begin
            cmd_valid = 1'h1;
            cmd_fast = f[0];
            tick;
            cmd_valid = 1'h0;
            `CHK(rate_sel, f[0] ? `BIL_RATE_HIGH : `BIL_RATE_MED);
            `CHK(binary_mode, 1'h0);
            tick;
        end
        enter(1'h0, 1'h0);
        cmd_valid = 1'h1;
        cmd_fast = 1'h1;
        tick;
        cmd_valid = 1'h0;
        tick;
        `CHK(rate_sel, `BIL_RATE_MED);
        for (int k = 0; k < 4; k++) begin
            pkt(8'h20, 32'(k * 32), 1'h0, 8'h05, 1'h1, 32'(k * 32), `BIL_ACK);
        end
        pkt(8'h20, 32'h40, 1'h0, 8'h05, 1'h1, 32'h40, `BIL_ACK);
        pkt(8'h20, 32'h60, 1'h1, 8'h05, 1'h0, 32'h0, `BIL_NAK);
        pkt(8'h10, 32'h80, 1'h0, 8'h05, 1'h0, 32'h0, `BIL_NAK);
        pkt(8'h20, 32'hA0, 1'h0, 8'h28, 1'h1, 32'hA0, `BIL_NAK);
        repeat (40) tick;
        pkt(8'h20, 32'h1000, 1'h0, 8'h03, 1'h1, 32'h1000, `BIL_ACK);
        pkt(8'h00, 32'h0, 1'h1, 8'h03, 1'h0, 32'h0, `BIL_NAK);
        `CHK(binary_mode, 1'h1);
        pkt(8'h00, 32'h1234, 1'h0, 8'h03, 1'h1, 32'h1020, `BIL_ACK);
        finish_load(`BIL_RATE_MED);
        tick;
        enter(1'h1, 1'h1);
        pkt(8'h20, 32'h20, 1'h0, 8'h02, 1'h1, 32'h20, `BIL_ACK);
        pkt(8'h00, 32'h0, 1'h0, 8'h02, 1'h0, 32'h0, `BIL_ACK);
        finish_load(`BIL_RATE_HIGH);
        close_out;
    end
endmodule : tb_binary_image_loader
`default_nettype wire
